/* include/acm_pkg.sv */
// Constants and types for the converter channel mux and request arbiter.
package acm_pkg;

  // ==========================================================================
  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 24;
  localparam int RES_W  = 10;
  localparam int NREQ   = 2;

  // ==========================================================================
  // Register offsets
  localparam logic [2:0] OFS_REQ_CTRL = 3'h0;
  localparam logic [2:0] OFS_ROUTE    = 3'h1;
  localparam logic [2:0] OFS_STATUS   = 3'h2;
  localparam logic [2:0] OFS_MASK     = 3'h3;
  localparam logic [2:0] OFS_RESULT_P = 3'h4;
  localparam logic [2:0] OFS_RESULT_S = 3'h5;

  // ==========================================================================
  // Request control fields
  localparam int CTL_ENABLE     = 0;
  localparam int CTL_HW_IGNORE  = 1;
  localparam int CTL_HOLD_OFF   = 2;
  localparam int CTL_SINGLE     = 3;
  localparam int CTL_HW_ARM     = 4;
  localparam int CTL_W          = 5;
  localparam int CTL_SW_START   = 8;
  localparam int CTL_SEC_SELECT = 23;
  localparam logic [4:0] CTL_RESET = 5'h00;

  // ==========================================================================
  // Routing fields
  localparam int RT_HALVE      = 0;
  localparam int RT_SEL_LO     = 1;
  localparam int RT_SEL_HI     = 2;
  localparam int RT_COIN       = 3;
  localparam int RT_REMOVAL_EN = 4;
  localparam int RT_OUT4_ROUTE = 5;
  localparam int RT_W          = 6;
  localparam logic [5:0] RT_RESET = 6'h00;

  // ==========================================================================
  // Status and mask fields
  localparam int ST_SENSE     = 0;
  localparam int ST_REMOVAL   = 1;
  localparam int ST_DONE_P    = 2;
  localparam int ST_DONE_S    = 3;
  localparam int ST_BUSY      = 4;
  localparam int ST_CURRENT   = 5;
  localparam int ST_DIE_WARM  = 6;
  localparam logic [2:0] MASK_RESET = 3'h7;

  // ==========================================================================
  // Channel 7 source codes
  localparam logic [1:0] CH7_AUX   = 2'h0;
  localparam logic [1:0] CH7_DIE   = 2'h1;
  localparam logic [1:0] CH7_USBID = 2'h2;
  localparam logic [1:0] CH7_ALT   = 2'h3;

  // ==========================================================================
  // Die temperature code at 25 degrees; one step is about 0.4244 degrees up.
  localparam logic [9:0] DIE_CODE_25C = 10'h2A8;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ             = 20;
  localparam int REMOVAL_DEBOUNCE_US = 1000;
  localparam int REMOVAL_DEBOUNCE_CYC = REMOVAL_DEBOUNCE_US * CLK_MHZ;

  typedef enum logic {ACM_IDLE, ACM_BUSY} acm_state_t;

endpackage

/* sim/acm_conv_model.sv */
// Behavioural converter core that answers start pulses after a set delay.
module acm_conv_model (
  input  wire logic       clk, srst, start, sec,
  input  wire logic [4:0] dly,
  input  wire logic [9:0] res_p, res_s,
  output logic            done,
  output logic      [9:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  logic       busy, cur;
  // The data lines toggle outside a completion or reset so a stale result never looks valid.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    data <= ~data;
    if (srst) begin
      busy <= 1'b0;
      data <= 10'h155;
    end else if (start) begin
      busy <= 1'b1;
      cnt  <= dly;
      cur  <= sec;
    end else if (busy && cnt == 5'h0) begin
      busy <= 1'b0;
      done <= 1'b1;
      data <= cur ? res_s : res_p;
    end else begin
      cnt <= cnt - 5'h1;
    end
  end
endmodule

/* sim/acm_top_asserts.sv */
// Port-level assertions for the channel mux and request arbiter.
module acm_top_asserts #(
  parameter int DEBOUNCE_CYCLES = acm_pkg::REMOVAL_DEBOUNCE_CYC
) (
  input wire logic                       CORE_CLK, SRST, REG_WR, REG_RD, REMOVAL_COMPARE,
  input wire logic [acm_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic                       CONV_DONE, CONV_START, CONV_REQ_SECONDARY,
  input wire logic                       CH5_DIRECT, REMOVAL_COMPARE_EN, CH7_ROUTE_VALID,
  input wire logic [1:0]                 CH7_SOURCE,
  input wire logic                       REMOVAL_IRQ, PRIMARY_DONE_IRQ, SECONDARY_DONE_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  int stable_cnt;
  // ==========================================================================
  // Helper logic
  // Counts cycles of a steady comparison while the removal check is powered.
  always_ff @(posedge CORE_CLK) begin
    if (SRST || !REMOVAL_COMPARE || !REMOVAL_COMPARE_EN) stable_cnt <= 0;
    else if (stable_cnt < DEBOUNCE_CYCLES) stable_cnt <= stable_cnt + 1;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // ==========================================================================
  // Properties
  start_pulse_a: assert property (CONV_START |=> !CONV_START)
    else $error("start pulse longer than one cycle");
  done_gap_a: assert property (CONV_DONE |=> !CONV_START)
    else $error("start right after completion");
  prim_irq_a: assert property (
    $rose(PRIMARY_DONE_IRQ) && !$past(REG_WR)
    |-> $past(CONV_DONE) && !$past(CONV_REQ_SECONDARY)) else $error("stray primary irq");
  sec_irq_a: assert property (
    $rose(SECONDARY_DONE_IRQ) && !$past(REG_WR)
    |-> $past(CONV_DONE) && $past(CONV_REQ_SECONDARY)) else $error("stray second irq");
  sec_read_zero_a: assert property ($past(REG_RD) |-> !REG_RDATA[23])
    else $error("select bit read back as one");
  route_valid_a: assert property (!CH7_ROUTE_VALID |-> CH7_SOURCE == 2'h3)
    else $error("route invalid for a fixed source");
  ch5_direct_a: assert property (CH5_DIRECT == !REMOVAL_COMPARE_EN)
    else $error("channel 5 mode disagrees with check");
  removal_deb_a: assert property (
    $rose(REMOVAL_IRQ) && !$past(REG_WR) && !$past(REG_WR, 2) |-> stable_cnt >= DEBOUNCE_CYCLES)
    else $error("removal irq before debounce");
  cover property (CONV_DONE ##[1:4] CONV_START);
  cover property ($rose(SECONDARY_DONE_IRQ));
  cover property ($rose(REMOVAL_IRQ));
endmodule

/* sim/acm_top_tb.sv */
// Self-checking bench for the channel mux and request arbiter.
module acm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CORE_CLK, SRST, REG_WR, REG_RD, HW_TRIGGER_PIN, REMOVAL_COMPARE, CONV_DONE;
  logic        CONV_START, CONV_REQ_SECONDARY, CH5_DIRECT, REMOVAL_COMPARE_EN, CH6_COIN_SELECT;
  logic        CH7_HALVE, CH7_ROUTE_VALID, REMOVAL_IRQ, PRIMARY_DONE_IRQ, SECONDARY_DONE_IRQ;
  logic [2:0]  REG_ADDR;
  logic [23:0] REG_WDATA, REG_RDATA;
  logic [9:0]  CONV_DATA, res_p, res_s;
  logic [1:0]  CH7_SOURCE;
  logic [4:0]  dly;
  logic [7:0]  seq;
  logic [5:0]  v;
  int          errors, checks_done, n_st, n0;
  acm_top #(.DEBOUNCE_CYCLES(4)) acm_top_inst (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .HW_TRIGGER_PIN(HW_TRIGGER_PIN), .REMOVAL_COMPARE(REMOVAL_COMPARE),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .CONV_START(CONV_START),
    .CONV_REQ_SECONDARY(CONV_REQ_SECONDARY), .CH5_DIRECT(CH5_DIRECT),
    .REMOVAL_COMPARE_EN(REMOVAL_COMPARE_EN), .CH6_COIN_SELECT(CH6_COIN_SELECT),
    .CH7_SOURCE(CH7_SOURCE), .CH7_HALVE(CH7_HALVE), .CH7_ROUTE_VALID(CH7_ROUTE_VALID),
    .REMOVAL_IRQ(REMOVAL_IRQ), .PRIMARY_DONE_IRQ(PRIMARY_DONE_IRQ),
    .SECONDARY_DONE_IRQ(SECONDARY_DONE_IRQ));
  acm_conv_model acm_conv_model_inst (.clk(CORE_CLK), .srst(SRST), .start(CONV_START),
    .sec(CONV_REQ_SECONDARY), .dly(dly), .res_p(res_p), .res_s(res_s), .done(CONV_DONE),
    .data(CONV_DATA));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One bus access; a read compares the data of the following cycle with d.
  task automatic acc(input logic w, input logic [2:0] a, input logic [23:0] d);
    @(posedge CORE_CLK);
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA} <= {w, !w, a, d};
    @(posedge CORE_CLK);
    {REG_WR, REG_RD} <= 2'b00;
    if (!w) #1 chk(REG_RDATA, d);
  endtask
  task automatic ctl(input logic [23:0] d);
    acc(1'b1, acm_pkg::OFS_REQ_CTRL, d);
  endtask
  task automatic trg();
    @(posedge CORE_CLK);
    HW_TRIGGER_PIN <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    HW_TRIGGER_PIN <= 1'b0;
  endtask
  task automatic starts(input int n);
    repeat (62) @(posedge CORE_CLK);
    chk(24'(n_st - n0), 24'(n));
    n0 = n_st;
  endtask
  task automatic dw();
    for (int i = 0; i < 80 && CONV_DONE !== 1'b1; i++) @(posedge CORE_CLK);
    repeat (3) @(posedge CORE_CLK);
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Processes
  always @(posedge CORE_CLK) begin
    if (CONV_START === 1'b1) begin
      n_st <= n_st + 1;
      seq  <= {seq[6:0], CONV_REQ_SECONDARY};
    end
  end
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    errors++;
    print_verdict();
  end
  initial begin
    {SRST, REG_WR, REG_RD, HW_TRIGGER_PIN, REMOVAL_COMPARE} = 5'h10;
    {REG_ADDR, REG_WDATA, res_p, res_s, seq} = '0;
    {errors, checks_done, n_st, n0} = '0;
    dly = 5'h1;
    void'($urandom(32'h710f));
    repeat (10) @(posedge CORE_CLK);
    SRST <= 1'b0;
    @(posedge CORE_CLK);
    chk(24'({CH5_DIRECT, CH7_ROUTE_VALID, REMOVAL_IRQ}), 24'h6);
    acc(1'b0, acm_pkg::OFS_MASK, 24'h7);
    for (int i = 0; i < 8; i++) begin
      v = {1'($urandom), 1'b0, 1'($urandom), i[1:0], 1'($urandom)};
      acc(1'b1, acm_pkg::OFS_ROUTE, 24'(v));
      acc(1'b0, acm_pkg::OFS_ROUTE, 24'(v));
      chk(24'({CH7_SOURCE, CH7_HALVE, CH6_COIN_SELECT}), 24'({v[2:1], v[0], v[3]}));
      chk(24'(CH7_ROUTE_VALID), 24'(v[2:1] != 2'h3 || v[5]));
    end
    acc(1'b1, acm_pkg::OFS_ROUTE, 24'h10);
    REMOVAL_COMPARE <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    REMOVAL_COMPARE <= 1'b0;
    repeat (12) @(posedge CORE_CLK);
    chk(24'({REMOVAL_IRQ, CH5_DIRECT, REMOVAL_COMPARE_EN}), 24'h1);
    REMOVAL_COMPARE <= 1'b1;
    repeat (14) @(posedge CORE_CLK);
    chk(24'(REMOVAL_IRQ), 24'h1);
    acc(1'b1, acm_pkg::OFS_ROUTE, 24'h0);
    acc(1'b1, acm_pkg::OFS_STATUS, 24'h2);
    repeat (14) @(posedge CORE_CLK);
    chk(24'(REMOVAL_IRQ), 24'h0);
    REMOVAL_COMPARE <= 1'b0;
    dly   <= 5'($urandom_range(1, 9));
    res_p <= 10'($urandom);
    res_s <= 10'($urandom);
    acc(1'b1, acm_pkg::OFS_MASK, 24'h5);
    ctl(24'h101);
    dw();
    chk(24'(PRIMARY_DONE_IRQ), 24'h0);
    acc(1'b1, acm_pkg::OFS_MASK, 24'h7);
    repeat (2) @(posedge CORE_CLK);
    chk(24'(PRIMARY_DONE_IRQ), 24'h1);
    ctl(24'h800105);
    dw();
    chk(24'({SECONDARY_DONE_IRQ, seq[0]}), 24'h3);
    ctl(24'h0);
    acc(1'b0, acm_pkg::OFS_RESULT_P, 24'(res_p));
    acc(1'b0, acm_pkg::OFS_RESULT_S, 24'(res_s));
    acc(1'b0, acm_pkg::OFS_REQ_CTRL, 24'h0);
    acc(1'b1, acm_pkg::OFS_STATUS, 24'hC);
    n0 = n_st;
    ctl(24'h110);
    trg();
    starts(0);
    ctl(24'h13);
    trg();
    starts(0);
    ctl(24'h19);
    trg();
    trg();
    starts(1);
    ctl(24'h11);
    ctl(24'h800011);
    trg();
    starts(2);
    chk(24'(seq[1:0]), 24'h1);
    dly <= 5'h19;
    ctl(24'h800015);
    ctl(24'h101);
    trg();
    starts(1);
    ctl(24'h800011);
    ctl(24'h101);
    trg();
    starts(2);
    chk(24'(seq[1:0]), 24'h1);
    ctl(24'h800101);
    ctl(24'h105);
    starts(2);
    chk(24'(seq[1:0]), 24'h2);
    print_verdict();
  end
endmodule
bind acm_top acm_top_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) acm_top_asserts_inst (.*);

/* src/acm_top.sv */
// Channel 5..7 routing, removal check and two-request conversion arbiter.
// Summary of operation
// - Channel 5 passes thermistor input unscaled normally.
// - Removal check runs only while enabled.
// - Input above 31/32 bias sets sense.
// - Channel 6 coin cell at 2/3 when enabled.
// - Channel 7 select codes and halve bit.
// - Alternate input needs shared output routed.
// - Die temperature 680 at 25 C.
// - Two requests share core, separate results.
// - Bit 23 write steers secondary request.
// - Bit 23 reads 0; only primary readable.
// - Per-request maskable completion interrupt.
// - First arrived trigger served first.
// - Hold-off drops other trigger, else remembered.
// - Software starts ignore hold-off.
// - Single shot accepts first hardware trigger.
// - Equal hold-off ties favour primary request.
// - Ignore bit disregards hardware trigger pin.
// - Enable low ignores all triggers.
//
// Design decisions made here: the strobed register port and the register addresses.
module acm_top #(
  parameter int DEBOUNCE_CYCLES = acm_pkg::REMOVAL_DEBOUNCE_CYC
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      SRST,
  input  wire logic [acm_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [acm_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output logic      [acm_pkg::DATA_W-1:0] REG_RDATA,
  input  wire logic                      HW_TRIGGER_PIN,
  input  wire logic                      REMOVAL_COMPARE,
  input  wire logic                      CONV_DONE,
  input  wire logic [acm_pkg::RES_W-1:0]  CONV_DATA,
  output logic                           CONV_START,
  output logic                           CONV_REQ_SECONDARY,
  output logic                           CH5_DIRECT,
  output logic                           REMOVAL_COMPARE_EN,
  output logic                           CH6_COIN_SELECT,
  output logic      [1:0]                CH7_SOURCE,
  output logic                           CH7_HALVE,
  output logic                           CH7_ROUTE_VALID,
  output logic                           REMOVAL_IRQ,
  output logic                           PRIMARY_DONE_IRQ,
  output logic                           SECONDARY_DONE_IRQ
);

  typedef struct packed {
    logic                                   trig_meta;
    logic                                   trig_sync;
    logic                                   trig_prev;
    logic                                   comp_meta;
    logic                                   comp_sync;
    logic [acm_pkg::NREQ-1:0][acm_pkg::CTL_W-1:0] ctrl;
    logic [acm_pkg::RT_W-1:0]               route;
    logic [2:0]                             mask;
    logic [acm_pkg::NREQ-1:0]               pending;
    logic [acm_pkg::NREQ-1:0]               shot_used;
    logic                                   older;
    acm_pkg::acm_state_t                    state;
    logic                                   cur;
    logic [acm_pkg::NREQ-1:0][acm_pkg::RES_W-1:0] result;
    logic [acm_pkg::NREQ-1:0]               done;
    logic                                   removal_flag;
    logic                                   die_warm;
    logic [15:0]                            deb_cnt;
    logic                                   start;
    logic [acm_pkg::DATA_W-1:0]             rdata;
    logic [2:0]                             irq;
  } acm_regs_t;

  acm_regs_t cur_q;
  acm_regs_t next_q;

  // ==========================================================================
  // Read decode
  function automatic logic [acm_pkg::DATA_W-1:0] read_word(
    input logic [acm_pkg::ADDR_W-1:0] addr,
    input acm_regs_t                  s
  );
    logic [acm_pkg::DATA_W-1:0] w;
    w = '0;
    unique case (addr)
      acm_pkg::OFS_REQ_CTRL: w[acm_pkg::CTL_W-1:0] = s.ctrl[0];
      acm_pkg::OFS_ROUTE:    w[acm_pkg::RT_W-1:0] = s.route;
      acm_pkg::OFS_STATUS: begin
        w[acm_pkg::ST_SENSE]    = s.comp_sync & s.route[acm_pkg::RT_REMOVAL_EN];
        w[acm_pkg::ST_REMOVAL]  = s.removal_flag;
        w[acm_pkg::ST_DONE_P]   = s.done[0];
        w[acm_pkg::ST_DONE_S]   = s.done[1];
        w[acm_pkg::ST_BUSY]     = (s.state == acm_pkg::ACM_BUSY);
        w[acm_pkg::ST_CURRENT]  = s.cur;
        w[acm_pkg::ST_DIE_WARM] = s.die_warm;
      end
      acm_pkg::OFS_MASK:     w[2:0] = s.mask;
      acm_pkg::OFS_RESULT_P: w[acm_pkg::RES_W-1:0] = s.result[0];
      acm_pkg::OFS_RESULT_S: w[acm_pkg::RES_W-1:0] = s.result[1];
      default:               w = '0;
    endcase
    return w;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic                     trig_rise;
    logic                     ctl_wr;
    logic                     sel;
    logic                     busy;
    logic [acm_pkg::NREQ-1:0] ev;
    logic [acm_pkg::NREQ-1:0] pend_now;
    logic                     pick;
    logic                     sense;
    trig_rise = 1'b0;
    ctl_wr    = 1'b0;
    sel       = 1'b0;
    busy      = 1'b0;
    ev        = '0;
    pend_now  = '0;
    pick      = 1'b0;
    sense     = 1'b0;
    next_q    = cur_q;

    next_q.trig_meta = HW_TRIGGER_PIN;
    next_q.trig_sync = cur_q.trig_meta;
    next_q.trig_prev = cur_q.trig_sync;
    next_q.comp_meta = REMOVAL_COMPARE;
    next_q.comp_sync = cur_q.comp_meta;
    next_q.start     = 1'b0;

    trig_rise = cur_q.trig_sync & ~cur_q.trig_prev;
    busy      = (cur_q.state == acm_pkg::ACM_BUSY);
    ctl_wr    = REG_WR && (REG_ADDR == acm_pkg::OFS_REQ_CTRL);
    sel       = REG_WDATA[acm_pkg::CTL_SEC_SELECT];

    // Register writes.
    if (ctl_wr) begin
      next_q.ctrl[sel] = REG_WDATA[acm_pkg::CTL_W-1:0];
    end
    if (REG_WR && REG_ADDR == acm_pkg::OFS_ROUTE) begin
      next_q.route = REG_WDATA[acm_pkg::RT_W-1:0];
    end
    if (REG_WR && REG_ADDR == acm_pkg::OFS_MASK) begin
      next_q.mask = REG_WDATA[2:0];
    end

    // Trigger acceptance per request.
    for (int r = 0; r < acm_pkg::NREQ; r++) begin
      if (trig_rise
          && cur_q.ctrl[r][acm_pkg::CTL_ENABLE]
          && !cur_q.ctrl[r][acm_pkg::CTL_HW_IGNORE]
          && cur_q.ctrl[r][acm_pkg::CTL_HW_ARM]
          && !(cur_q.ctrl[r][acm_pkg::CTL_SINGLE] && cur_q.shot_used[r])
          && !(busy && cur_q.cur != r[0]
               && cur_q.ctrl[r][acm_pkg::CTL_HOLD_OFF])) begin
        ev[r] = 1'b1;
        next_q.shot_used[r] = cur_q.ctrl[r][acm_pkg::CTL_SINGLE];
      end
      if (ctl_wr && sel == r[0]
          && REG_WDATA[acm_pkg::CTL_SW_START]
          && REG_WDATA[acm_pkg::CTL_ENABLE]) begin
        ev[r] = 1'b1;
      end
      if (ctl_wr && sel == r[0] && !REG_WDATA[acm_pkg::CTL_SINGLE]) begin
        next_q.shot_used[r] = 1'b0;
      end
    end

    // Arrival order; a tie favours primary unless only it holds off.
    pend_now = cur_q.pending;
    if (ev[0] && ev[1] && pend_now == '0) begin
      next_q.older = (cur_q.ctrl[0][acm_pkg::CTL_HOLD_OFF]
                      && !cur_q.ctrl[1][acm_pkg::CTL_HOLD_OFF]);
    end else if (ev[1] && !pend_now[1] && pend_now[0]) begin
      next_q.older = 1'b0;
    end else if (ev[0] && !pend_now[0] && pend_now[1]) begin
      next_q.older = 1'b1;
    end else if (pend_now == '0 && ev != '0) begin
      next_q.older = ev[1];
    end
    next_q.pending = cur_q.pending | ev;

    // Shared converter sequencing.
    unique case (cur_q.state)
      acm_pkg::ACM_IDLE: begin
        if (cur_q.pending != '0) begin
          pick = (cur_q.pending == 2'h3) ? cur_q.older : cur_q.pending[1];
          next_q.cur           = pick;
          next_q.pending[pick] = ev[pick];
          next_q.start         = 1'b1;
          next_q.state         = acm_pkg::ACM_BUSY;
          if (ev != '0 && ev[pick]) begin
            next_q.older = ~pick;
          end
        end
      end
      acm_pkg::ACM_BUSY: begin
        if (CONV_DONE) begin
          next_q.result[cur_q.cur] = CONV_DATA;
          next_q.state             = acm_pkg::ACM_IDLE;
          if (cur_q.route[acm_pkg::RT_SEL_HI:acm_pkg::RT_SEL_LO] == acm_pkg::CH7_DIE) begin
            next_q.die_warm = (CONV_DATA >= acm_pkg::DIE_CODE_25C);
          end
        end
      end
    endcase

    // Sticky done flags; a new completion beats a clear in the same cycle.
    for (int r = 0; r < acm_pkg::NREQ; r++) begin
      if (REG_WR && REG_ADDR == acm_pkg::OFS_STATUS
          && REG_WDATA[acm_pkg::ST_DONE_P + r]) begin
        next_q.done[r] = 1'b0;
      end
      if (busy && CONV_DONE && cur_q.cur == r[0]) begin
        next_q.done[r] = 1'b1;
      end
    end

    // Removal check with debounce.
    sense = cur_q.comp_sync && cur_q.route[acm_pkg::RT_REMOVAL_EN];
    if (!sense) begin
      next_q.deb_cnt = '0;
    end else if (cur_q.deb_cnt < 16'(DEBOUNCE_CYCLES)) begin
      next_q.deb_cnt = cur_q.deb_cnt + 16'h0001;
    end
    if (REG_WR && REG_ADDR == acm_pkg::OFS_STATUS
        && REG_WDATA[acm_pkg::ST_REMOVAL]) begin
      next_q.removal_flag = 1'b0;
    end
    if (sense && cur_q.deb_cnt == 16'(DEBOUNCE_CYCLES - 1)) begin
      next_q.removal_flag = 1'b1;
    end

    next_q.irq = next_q.mask & {next_q.done[1], next_q.done[0],
                                next_q.removal_flag};
    next_q.rdata = REG_RD ? read_word(REG_ADDR, cur_q) : '0;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      cur_q              <= '0;
      cur_q.ctrl[0]      <= acm_pkg::CTL_RESET;
      cur_q.ctrl[1]      <= acm_pkg::CTL_RESET;
      cur_q.route        <= acm_pkg::RT_RESET;
      cur_q.mask         <= acm_pkg::MASK_RESET;
      cur_q.state        <= acm_pkg::ACM_IDLE;
    end else begin
      cur_q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs taken from flip-flops, except CH5_DIRECT and CH7_ROUTE_VALID, which are decoded from route bits
  assign REG_RDATA          = cur_q.rdata;
  assign CONV_START         = cur_q.start;
  assign CONV_REQ_SECONDARY = cur_q.cur;
  assign CH5_DIRECT         = ~cur_q.route[acm_pkg::RT_REMOVAL_EN];
  assign REMOVAL_COMPARE_EN = cur_q.route[acm_pkg::RT_REMOVAL_EN];
  assign CH6_COIN_SELECT    = cur_q.route[acm_pkg::RT_COIN];
  assign CH7_SOURCE         = cur_q.route[acm_pkg::RT_SEL_HI:acm_pkg::RT_SEL_LO];
  assign CH7_HALVE          = cur_q.route[acm_pkg::RT_HALVE];
  assign CH7_ROUTE_VALID    = (CH7_SOURCE != acm_pkg::CH7_ALT)
                              || cur_q.route[acm_pkg::RT_OUT4_ROUTE];
  assign REMOVAL_IRQ        = cur_q.irq[0];
  assign PRIMARY_DONE_IRQ   = cur_q.irq[1];
  assign SECONDARY_DONE_IRQ = cur_q.irq[2];

endmodule
